//--- include/psr_pkg.sv
// constants for the pipelined burst sram block
package psr_pkg;
  localparam int ADDR_W      = 18;
  localparam int LANE_W      = 9;
  localparam int WORD_W      = 2 * LANE_W;
  localparam int DEPTH       = 262144;
  localparam int BURST_W     = 2;
  localparam int LANE_A_LSB  = 0;
  localparam int LANE_B_LSB  = LANE_W;
  localparam logic [1:0] CNT_RESET = 2'h0;
endpackage

//--- hw/psr_burst_sram.sv
// pipelined burst sram: array, burst counter, write decode, output register

// Overview of operation
// - The array holds 256K words of 18 bits in two 9-bit byte lanes a and b.
// - Address, write data and all controls except order select are sampled on the rising edge.
// - Either address strobe starts a burst and latches the external address as its start.
// - A 2-bit counter produces the low address bits of later burst beats.
// - The counter steps only while burst advance is asserted, in the order chosen by the select.
// - Writes start on the clock edge and need no external write pulse.
// - Lane-a byte write gates lane a only and lane-b byte write gates lane b only.
// - Write enable with some byte writes writes only those lanes and leaves the rest.
// - Global write, or write enable with both byte writes, writes both lanes.
// - Read data passes an output register and reaches the pins two edges after the address is sampled.
// - Order select low gives linear order, high gives interleaved, and it is not registered.
// - With primary enable negated the processor strobe is ignored and the controller strobe deselects.
// - Output enable low drives the data pins from one edge after read data becomes valid to one edge after it ends; high releases them from the next rising edge.
// - A strobe selects the chip only with depth enable high and depth enable low asserted too.
module psr_burst_sram
  import psr_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int LW = LANE_W
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst,
  // address and strobes
  input  wire logic [AW-1:0]   sync_address,
  input  wire logic            proc_addr_strobe_n,
  input  wire logic            ctrl_addr_strobe_n,
  input  wire logic            burst_step_n,
  input  wire logic            burst_order_sel,
  // chip enables
  input  wire logic            chip_enable_primary_n,
  input  wire logic            chip_enable_depth_hi,
  input  wire logic            chip_enable_depth_lo_n,
  // write controls and output enable
  input  wire logic            write_enable_n,
  input  wire logic            lane_a_write_n,
  input  wire logic            lane_b_write_n,
  input  wire logic            all_lanes_write_n,
  input  wire logic            out_enable_n,
  // data lanes, split into in, out and enable
  input  wire logic [LW-1:0]   data_lane_a_in,
  input  wire logic [LW-1:0]   data_lane_b_in,
  output logic      [LW-1:0]   data_lane_a_out,
  output logic      [LW-1:0]   data_lane_b_out,
  output logic                 data_lane_oe
);

  localparam int WW = 2 * LW;

  logic [WW-1:0] mem [0:(1<<AW)-1];

  // sampled inputs; the sample stage is the device's input register
  logic [AW-1:0] addr_q;
  logic          proc_addr_strobe_n_q, ctrl_addr_strobe_n_q, step_q, ce1_q, ce2_q, ce3_q;
  logic          we_q, wa_q, wb_q, gw_q;
  logic [WW-1:0] din_q;
  logic [AW-1:0] base_q;
  logic [1:0]    start_q, cnt_q, cnt_d;
  logic          sel_q, sel_d;
  logic          rd_q;
  logic [WW-1:0] rdata_q, dout_q;
  logic          dout_v_q;
  logic          oe_q;

  // input register on the rising edge
  always_ff @(posedge clk_sys) begin
    addr_q <= sync_address;
    proc_addr_strobe_n_q <= ~proc_addr_strobe_n;
    ctrl_addr_strobe_n_q <= ~ctrl_addr_strobe_n;
    step_q <= ~burst_step_n;
    ce1_q  <= ~chip_enable_primary_n;
    ce2_q  <= chip_enable_depth_hi;
    ce3_q  <= ~chip_enable_depth_lo_n;
    we_q   <= ~write_enable_n;
    wa_q   <= ~lane_a_write_n;
    wb_q   <= ~lane_b_write_n;
    gw_q   <= ~all_lanes_write_n;
    din_q  <= {data_lane_b_in, data_lane_a_in};
  end

  wire enabled   = ce1_q & ce2_q & ce3_q;
  // processor strobe blocked while primary enable negated
  wire proc_addr_strobe_n_ok   = proc_addr_strobe_n_q & ce1_q;
  wire strobe    = proc_addr_strobe_n_ok | ctrl_addr_strobe_n_q;
  wire start_now = strobe & enabled;
  wire desel_now = strobe & ~enabled;

  // next beat: linear count or interleaved xor
  wire [1:0] lin_next = cnt_q + 2'h1;
  wire [1:0] beat     = (cnt_q ^ start_q) + 2'h1;
  wire [1:0] int_next = start_q ^ beat;
  // order select read live, not registered
  wire [1:0] step_val = burst_order_sel ? int_next : lin_next;

  always_comb begin
    cnt_d = cnt_q;
    sel_d = sel_q;
    if (start_now) begin
      cnt_d = addr_q[1:0];
      sel_d = 1'b1;
    end else if (desel_now) begin
      sel_d = 1'b0;
    end else if (step_q) begin
      cnt_d = step_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q   <= CNT_RESET;
      start_q <= CNT_RESET;
      sel_q   <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      if (start_now) begin
        start_q <= addr_q[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (start_now) begin
      base_q <= addr_q;
    end
  end

  wire [AW-1:0] cur_addr = start_now ? addr_q : {base_q[AW-1:2], cnt_d};
  wire          active   = start_now | (sel_q & ~desel_now);
  // processor strobe cycles are always reads; writes come on later beats
  wire          wr_ok    = active & ~(start_now & proc_addr_strobe_n_ok);
  // both lanes on global write or write enable with both bytes
  wire          all_wr   = gw_q | (we_q & wa_q & wb_q);
  wire          wr_a     = wr_ok & (all_wr | (we_q & wa_q));
  wire          wr_b     = wr_ok & (all_wr | (we_q & wb_q));
  wire          is_rd    = active & ~(wr_a | wr_b);

  // self-timed write on the edge, lane by lane
  always_ff @(posedge clk_sys) begin
    if (wr_a) begin
      mem[cur_addr][LANE_A_LSB +: LW] <= din_q[LANE_A_LSB +: LW];
    end
    if (wr_b) begin
      mem[cur_addr][LW +: LW] <= din_q[LW +: LW];
    end
    rdata_q <= mem[cur_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q     <= 1'b0;
      dout_q   <= '0;
      dout_v_q <= 1'b0;
    end else begin
      rd_q     <= is_rd;
      dout_v_q <= rd_q;
      if (rd_q) begin
        dout_q <= rdata_q;
      end
    end
  end

  // output enable has no edge in the real part; here it is
  // sampled once per clock so the port stays a flip-flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~out_enable_n & dout_v_q;
    end
  end

  assign data_lane_a_out = dout_q[LANE_A_LSB +: LW];
  assign data_lane_b_out = dout_q[LW +: LW];
  assign data_lane_oe    = oe_q;

  // checks
  sequence s_start;
    start_now;
  endsequence

  chk_proc_addr_strobe_n_blocked: assert property (@(posedge clk_sys) disable iff (rst)
    (proc_addr_strobe_n_q & ~ce1_q & ~ctrl_addr_strobe_n_q) |-> ##1 (sel_q == $past(sel_q)))
    else $error("processor strobe acted while disabled");
  chk_ctrl_addr_strobe_n_deselect: assert property (@(posedge clk_sys) disable iff (rst)
    (ctrl_addr_strobe_n_q & ~ce1_q) |=> !sel_q)
    else $error("controller strobe did not deselect");
  chk_start_latch: assert property (@(posedge clk_sys) disable iff (rst)
    s_start |=> (cnt_q == $past(addr_q[1:0])) && sel_q)
    else $error("burst start not latched");
  chk_linear_step: assert property (@(posedge clk_sys) disable iff (rst)
    (!strobe && step_q && !burst_order_sel) |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("linear step wrong");
  chk_inter_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    (s_start ##1 (!strobe && step_q && burst_order_sel) [*4])
    |=> cnt_q == $past(start_q, 1))
    else $error("interleaved burst did not wrap");
  chk_hold_addr: assert property (@(posedge clk_sys) disable iff (rst)
    (!strobe && !step_q) |=> $stable(cnt_q))
    else $error("address moved without advance");
  chk_depth_enable: assert property (@(posedge clk_sys) disable iff (rst)
    (strobe && !(ce2_q && ce3_q)) |=> !sel_q)
    else $error("depth enables ignored");
  chk_read_latency: assert property (@(posedge clk_sys) disable iff (rst)
    (is_rd && !wr_a && !wr_b) |-> ##2 dout_v_q)
    else $error("read data not in output register");
  chk_global_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_ok && gw_q) |-> (wr_a && wr_b))
    else $error("global write missed a lane");
  chk_lane_gate: assert property (@(posedge clk_sys) disable iff (rst)
    (!gw_q && !wa_q) |-> !wr_a)
    else $error("lane a written without its byte write");
  chk_oe_release: assert property (@(posedge clk_sys) disable iff (rst)
    out_enable_n |=> !data_lane_oe)
    else $error("data driven while output disabled");

endmodule

//--- sim/psr_host_model.sv
// host bus model: one bus beat per clock on the burst sram inputs
module psr_host_model (
  // clock
  input  wire logic clk_sys,
  // address, strobes, primary enable and write controls
  output logic [17:0] sync_address,
  output logic        proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
  output logic        write_enable_n, lane_a_write_n, lane_b_write_n,
  output logic        all_lanes_write_n, chip_enable_primary_n,
  // write data
  output logic [8:0]  data_lane_a_in, data_lane_b_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    beat_set(8'h7f, 18'h0, 18'h0);
  end
  // change after the falling edge, settled by the rising one
  task automatic beat_set(logic [7:0] c, logic [17:0] a, logic [17:0] d);
    {chip_enable_primary_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = c[7:4];
    {write_enable_n, lane_a_write_n, lane_b_write_n, all_lanes_write_n} = c[3:0];
    sync_address = a;
    {data_lane_b_in, data_lane_a_in} = d;
  endtask
  task automatic beat(logic [7:0] c, logic [17:0] a, logic [17:0] d);
    @(negedge clk_sys);
    beat_set(c, a, d);
  endtask
endmodule

//--- sim/pipelined_burst_sram_bench.sv
// self-checking bench for the pipelined burst sram
module pipelined_burst_sram_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, burst_order_sel = 0, out_enable_n = 0;
  logic chip_enable_depth_hi = 1, chip_enable_depth_lo_n = 0;
  logic [17:0] sync_address;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, write_enable_n;
  logic lane_a_write_n, lane_b_write_n, all_lanes_write_n, chip_enable_primary_n;
  logic [8:0] data_lane_a_in, data_lane_b_in, data_lane_a_out, data_lane_b_out;
  logic data_lane_oe;
  int seed = 53886, cyc = 0, n_fail = 0, total_checks = 0, qt[$];
  logic [17:0] qd[$], mem[int], a;
  logic [7:0] lanes[4] = '{8'h5e, 8'h53, 8'h55, 8'h51};
  psr_burst_sram dut (.*);
  psr_host_model host (.*);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  function automatic logic [17:0] merge(logic [7:0] c, logic [17:0] o, d);
    logic wa, wb;
    wa = !c[0] || (!c[3] && !c[2]);
    wb = !c[0] || (!c[3] && !c[1]);
    return {wb ? d[17:9] : o[17:9], wa ? d[8:0] : o[8:0]};
  endfunction
  function automatic logic [17:0] nxt(logic [17:0] s, logic [1:0] k, logic o);
    return {s[17:2], o ? s[1:0] ^ k : s[1:0] + k};
  endfunction
  task automatic chk(logic [17:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] c, logic [17:0] ad, d, bit ok);
    host.beat(c, ad, d);
    if (ok) mem[ad] = merge(c, mem.exists(ad) ? mem[ad] : d, d);
  endtask
  // reads land two edges after the taking edge
  task automatic rd(logic [7:0] c, logic [17:0] ad, e);
    host.beat(c, ad, ~ad);
    qt.push_back(cyc + 3);
    qd.push_back(e);
  endtask
  always @(negedge clk_sys)
    if (qt.size() && qt[0] == cyc) begin
      void'(qt.pop_front());
      chk({data_lane_b_out, data_lane_a_out}, qd.pop_front());
    end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    rst = 0;
    a = 18'($random(seed));
    for (int i = 0; i < 4; i++) begin
      wr(lanes[i], a, 18'($random(seed)), 1);
      rd(8'h5f, a, mem[a]);
    end
    // unselected strobes: enables change one idle beat ahead
    for (int i = 0; i < 3; i++) begin
      host.beat(8'h7f, ~a, 18'h0);
      chip_enable_depth_hi = (i != 1);
      chip_enable_depth_lo_n = (i == 2);
      wr(i ? 8'h5e : 8'hde, a, ~mem[a], 0);
      host.beat(8'h7f, ~a, 18'h0);
      chip_enable_depth_hi = 1;
      chip_enable_depth_lo_n = 0;
    end
    wr(8'h9e, a, ~mem[a], 0);
    rd(8'h5f, a, mem[a]);
    for (int o = 0; o < 2; o++) begin
      burst_order_sel = o[0];
      a = 18'($random(seed));
      for (int k = 0; k < 4; k++) wr(8'h5e, {a[17:2], 2'(k)}, 18'($random(seed)), 1);
      rd(o ? 8'h3f : 8'h5f, a, mem[a]);
      for (int k = 1; k < 5; k++) rd(8'h6f, ~a, mem[nxt(a, 2'(k), o[0])]);
      rd(8'h7f, ~a, mem[nxt(a, 2'h0, o[0])]);
    end
    repeat (5) host.beat(8'h7f, ~a, 18'h0);
    chk({17'h0, data_lane_oe}, 18'h1);
    out_enable_n = 1;
    repeat (2) host.beat(8'h7f, ~a, 18'h0);
    chk({17'h0, data_lane_oe}, 18'h0);
    conclude();
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
endmodule
